// File: src/fpsi_bus_if.sv
// Events passed from the pin capture stage to the command and status core
`timescale 1ns/1ps
`default_nettype none
interface fpsi_bus_if;
	logic wr_evt;
	logic wr_sync;
	logic [23:0] wr_addr;
	logic [15:0] wr_data;
	logic rd_evt;
	logic [23:0] rd_addr;
	logic burst_start;
	logic clk_rise;
	logic ce_low;
	logic out_en;
	modport cap (output wr_evt, wr_sync, wr_addr, wr_data, rd_evt, rd_addr,
		burst_start, clk_rise, ce_low, out_en);
	modport core (input wr_evt, wr_sync, wr_addr, wr_data, rd_evt, rd_addr,
		burst_start, clk_rise, ce_low, out_en);
endinterface
`default_nettype wire

// File: src/fpsi_capture.sv
// Pin synchronisers, edge detection and address capture for write and read cycles
`timescale 1ns/1ps
`default_nettype none
module fpsi_capture (
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce_n,
	input wire logic address_valid_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic link_clk,
	input wire logic [23:0] addr,
	input wire logic [15:0] dq_in,
	input wire logic sync_read_mode,
	fpsi_bus_if.cap bus
);
	localparam int NC = 5;
	logic [NC-1:0] pin_raw;
	logic [NC-1:0] sy1;
	logic [NC-1:0] sy2;
	logic [NC-1:0] sy3;
	logic [23:0] addr_s1;
	logic [23:0] addr_s2;
	logic [15:0] data_s1;
	logic [15:0] data_s2;
	logic [23:0] async_addr;
	logic [23:0] sync_addr;
	logic armed;
	logic done;

	assign pin_raw = {link_clk, oe_n, we_n, address_valid_n, ce_n};

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	for (genvar i = 0; i < NC; i++)
	begin : g_sync
		always_ff @(posedge clock)
		begin
			sy1[i] <= pin_raw[i];
			sy2[i] <= sy1[i];
			sy3[i] <= sy2[i];
		end
	end

	always_ff @(posedge clock)
	begin
		addr_s1 <= addr;
		addr_s2 <= addr_s1;
		data_s1 <= dq_in;
		data_s2 <= data_s1;
	end

	wire ce_l = ~sy2[0];
	wire avd_l = ~sy2[1];
	wire we_l = ~sy2[2];
	wire oe_l = ~sy2[3];
	wire we_fall = we_l & sy3[2];
	wire we_rise = ~we_l & ~sy3[2];
	wire oe_fall = oe_l & sy3[3];
	wire ce_fall = ce_l & sy3[0];
	wire lk_rise = sy2[4] & ~sy3[4];
	// Clocked address use needs synchronous read mode; otherwise the strobe address wins
	wire use_sync = armed & sync_read_mode;
	wire wr_take = we_rise & ce_l;
	wire new_read = ((oe_fall & ce_l) | (ce_fall & oe_l)) & ~we_l;

	// ----------------------------------------
	// Address capture
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			async_addr <= '0;
			sync_addr <= '0;
			armed <= 1'b0;
			done <= 1'b0;
			bus.wr_evt <= 1'b0;
			bus.wr_sync <= 1'b0;
			bus.wr_addr <= '0;
			bus.wr_data <= '0;
			bus.rd_evt <= 1'b0;
			bus.rd_addr <= '0;
			bus.burst_start <= 1'b0;
			bus.clk_rise <= 1'b0;
			bus.ce_low <= 1'b0;
			bus.out_en <= 1'b0;
		end
		else
		begin
			if (we_fall && ce_l)
				async_addr <= addr_s2;
			// Re-arming needs chip select or address valid to have gone high
			if (!ce_l || !avd_l)
				done <= 1'b0;
			if (!ce_l)
				armed <= 1'b0;
			else if (wr_take && use_sync)
			begin
				armed <= 1'b0;
				done <= 1'b1;
			end
			else if (lk_rise && avd_l && !done)
			begin
				sync_addr <= addr_s2;
				armed <= 1'b1;
			end
			if (avd_l && ce_l)
				bus.rd_addr <= addr_s2;
			bus.wr_evt <= wr_take;
			bus.wr_sync <= use_sync;
			bus.wr_addr <= use_sync ? sync_addr : async_addr;
			bus.wr_data <= data_s2;
			bus.rd_evt <= new_read;
			bus.burst_start <= lk_rise & ce_l & avd_l & ~we_l & sync_read_mode;
			bus.clk_rise <= lk_rise;
			bus.ce_low <= ce_l;
			bus.out_en <= oe_l & ce_l & ~we_l;
		end
	end
endmodule
`default_nettype wire

// File: src/fpsi_flash_prog_status.sv
// Program and erase command path, status polling and burst ready generation
// How it works
// - In asynchronous read mode, only strobe-timed program cycles are accepted
// - Synchronous read mode accepts both asynchronous and clocked program cycles
// - Asynchronous program latches the address on the write strobe falling edge
// - Synchronous program latches the address on the rising link clock edge
// - Unlock cycles ignore upper address bits 23 to 14
// - Sector erase accept window closes at most 50 us after the erase command
// - Activity toggle bit flips per status read while busy, stops when done
// - Polled data bit reads inverted while busy, true data once complete
// - Suspend toggle bit flips only for reads inside the erase-suspended sector
// - A new read cycle starts by output strobe or chip select falling
// - Ready lead bit one: ready with data; zero: one clock earlier
// - At 66 MHz or less with crossing bit zero, no boundary wait states
// - Extra delay cycles, ready low, at start address plus one to three
// - Wait field codes 0 to 5 give 2 to 7 waits; 110, 111 reserved
`timescale 1ns/1ps
`default_nettype none
module fpsi_flash_prog_status (
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce_n,
	input wire logic address_valid_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic link_clk,
	input wire logic [23:0] addr,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe,
	output logic rdy,
	input wire logic sync_read_mode,
	input wire logic ready_lead_select,
	input wire logic boundary_crossing_select,
	input wire logic [2:0] wait_state_field,
	input wire logic freq_above_66,
	input wire logic alg_busy,
	input wire logic erase_suspended,
	input wire logic [9:0] suspended_sector,
	input wire logic [15:0] array_data,
	output logic [23:0] read_addr,
	output logic prog_evt,
	output logic [23:0] prog_addr,
	output logic [15:0] prog_data,
	output logic erase_sector_evt,
	output logic [9:0] erase_sector,
	output logic erase_go
);
	fpsi_bus_if bus ();

	fpsi_capture u_capture (
		.clock(clock),
		.nrst(nrst),
		.ce_n(ce_n),
		.address_valid_n(address_valid_n),
		.we_n(we_n),
		.oe_n(oe_n),
		.link_clk(link_clk),
		.addr(addr),
		.dq_in(dq_in),
		.sync_read_mode(sync_read_mode),
		.bus(bus)
	);

	fpsi_pkg::fpsi_seq_t state;
	logic [fpsi_pkg::WIN_W-1:0] win_cnt;
	logic poll_bit;
	logic act_tog;
	logic susp_tog;
	logic burst_on;
	logic [2:0] wait_cnt;
	logic extra;
	logic [2:0] offset;
	logic [23:0] burst_addr;
	logic valid;
	logic early;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	localparam logic [fpsi_pkg::WIN_W-1:0] WIN_LAST =
		fpsi_pkg::WIN_W'(fpsi_pkg::ERASE_ACCEPT_CYC - 1);
	wire [7:0] wr_code = bus.wr_data[7:0];
	wire [fpsi_pkg::LOW_W-1:0] lo_addr = bus.wr_addr[fpsi_pkg::LOW_W-1:0];
	wire hit_a = lo_addr == fpsi_pkg::UNLOCK_ADDR_A;
	wire is_ua = hit_a && wr_code == fpsi_pkg::CODE_UNLOCK_A;
	wire is_ub = lo_addr == fpsi_pkg::UNLOCK_ADDR_B && wr_code == fpsi_pkg::CODE_UNLOCK_B;
	wire is_reset = bus.wr_evt && wr_code == fpsi_pkg::CODE_RESET;
	wire is_sector = wr_code == fpsi_pkg::CODE_SECTOR;
	wire win_end = state == fpsi_pkg::S_EWIN && (win_cnt == WIN_LAST ||
		(bus.wr_evt && !is_sector));

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			state <= fpsi_pkg::S_IDLE;
			win_cnt <= '0;
			poll_bit <= 1'b0;
			prog_evt <= 1'b0;
			prog_addr <= '0;
			prog_data <= '0;
			erase_sector_evt <= 1'b0;
			erase_sector <= '0;
			erase_go <= 1'b0;
		end
		else
		begin
			prog_evt <= 1'b0;
			erase_sector_evt <= 1'b0;
			erase_go <= win_end;
			win_cnt <= state == fpsi_pkg::S_EWIN ? win_cnt + 1'b1 : '0;
			if (is_reset && state != fpsi_pkg::S_EWIN)
				state <= fpsi_pkg::S_IDLE;
			else if (win_end)
				state <= fpsi_pkg::S_IDLE;
			else if (bus.wr_evt)
			begin
				unique case (state)
					fpsi_pkg::S_IDLE:
						state <= is_ua ? fpsi_pkg::S_UNLK2 : fpsi_pkg::S_IDLE;
					fpsi_pkg::S_UNLK2:
						state <= is_ub ? fpsi_pkg::S_CMD : fpsi_pkg::S_IDLE;
					fpsi_pkg::S_CMD:
						if (hit_a && wr_code == fpsi_pkg::CODE_PROGRAM)
							state <= fpsi_pkg::S_PROG;
						else if (hit_a && wr_code == fpsi_pkg::CODE_ERASE)
							state <= fpsi_pkg::S_ERS1;
						else
							state <= fpsi_pkg::S_IDLE;
					fpsi_pkg::S_PROG:
					begin
						prog_evt <= 1'b1;
						prog_addr <= bus.wr_addr;
						prog_data <= bus.wr_data;
						poll_bit <= ~bus.wr_data[fpsi_pkg::POLL_BIT];
						state <= fpsi_pkg::S_IDLE;
					end
					fpsi_pkg::S_ERS1:
						state <= is_ua ? fpsi_pkg::S_ERS2 : fpsi_pkg::S_IDLE;
					fpsi_pkg::S_ERS2:
						state <= is_ub ? fpsi_pkg::S_ERS3 : fpsi_pkg::S_IDLE;
					fpsi_pkg::S_ERS3, fpsi_pkg::S_EWIN:
						if (is_sector)
						begin
							erase_sector_evt <= 1'b1;
							erase_sector <= bus.wr_addr[23:fpsi_pkg::LOW_W];
							// Erased cells read one, so the poll bit reads zero
							poll_bit <= 1'b0;
							state <= fpsi_pkg::S_EWIN;
						end
						else
							state <= fpsi_pkg::S_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Status view
	// ----------------------------------------
	wire in_susp = erase_suspended &&
		bus.rd_addr[23:fpsi_pkg::LOW_W] == suspended_sector;
	wire [15:0] status_word = {array_data[15:8], poll_bit, act_tog, array_data[5:3],
		susp_tog, array_data[1:0]};
	wire [15:0] view = (alg_busy || in_susp) ? status_word : array_data;

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			act_tog <= 1'b0;
			susp_tog <= 1'b0;
		end
		else if (bus.rd_evt)
		begin
			if (alg_busy)
				act_tog <= ~act_tog;
			if (in_susp)
				susp_tog <= ~susp_tog;
		end
	end

	// ----------------------------------------
	// Burst wait states and ready
	// ----------------------------------------
	wire [2:0] wait_code = wait_state_field > fpsi_pkg::WAIT_MAX_CODE ?
		fpsi_pkg::WAIT_MAX_CODE : wait_state_field;
	wire [2:0] wait_total = 3'(wait_code + fpsi_pkg::WAIT_BASE);
	wire emit = wait_cnt == 3'h1 || (wait_cnt == 3'h0 && !extra);
	wire [23:0] nxt_addr = burst_addr + 24'h1;
	wire [2:0] off_next = offset == fpsi_pkg::OFFSET_SAT ? offset : 3'(offset + 3'h1);
	// Only a slow clock with the crossing bit clear skips the boundary stall
	wire bnd = off_next != fpsi_pkg::OFFSET_SAT && nxt_addr[1:0] == 2'h0 &&
		(freq_above_66 || boundary_crossing_select);
	wire [2:0] nw = wait_cnt != 3'h0 ? 3'(wait_cnt - 3'h1) : 3'h0;
	wire ne = emit ? bnd : 1'b0;
	wire will_emit = nw == 3'h1 || (nw == 3'h0 && !ne);

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			burst_on <= 1'b0;
			wait_cnt <= '0;
			extra <= 1'b0;
			offset <= fpsi_pkg::OFFSET_RST;
			burst_addr <= '0;
			valid <= 1'b0;
			early <= 1'b0;
		end
		else if (!bus.ce_low)
			burst_on <= 1'b0;
		else if (bus.burst_start)
		begin
			burst_on <= 1'b1;
			wait_cnt <= wait_total;
			extra <= 1'b0;
			offset <= fpsi_pkg::OFFSET_RST;
			burst_addr <= bus.rd_addr;
			valid <= 1'b0;
			early <= 1'b0;
		end
		else if (burst_on && bus.clk_rise)
		begin
			wait_cnt <= nw;
			extra <= ne;
			valid <= emit;
			early <= will_emit;
			if (emit)
			begin
				burst_addr <= nxt_addr;
				offset <= off_next;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			dq_out <= '0;
			read_addr <= '0;
		end
		else
		begin
			read_addr <= burst_on ? burst_addr : bus.rd_addr;
			// The core answers read_addr one cycle late; link edges are far apart
			if (!burst_on || (bus.clk_rise && emit))
				dq_out <= view;
		end
	end

	assign dq_oe = bus.out_en;
	assign rdy = !burst_on || (ready_lead_select ? valid : early);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	chk_sync_write_mode: assert property (
		bus.wr_evt && bus.wr_sync |-> $past(sync_read_mode, 1))
		else $error("clocked program accepted outside synchronous read mode");
	chk_unlock_upper: assert property (
		state == fpsi_pkg::S_IDLE && bus.wr_evt && is_ua && !is_reset
		|=> state == fpsi_pkg::S_UNLK2)
		else $error("unlock cycle not decoded on low address bits");
	chk_window_bound: assert property (
		state == fpsi_pkg::S_EWIN |-> win_cnt <= WIN_LAST)
		else $error("erase accept window overran");
	chk_window_close: assert property (
		state == fpsi_pkg::S_EWIN && win_cnt == WIN_LAST
		|=> erase_go && state == fpsi_pkg::S_IDLE)
		else $error("erase did not proceed at window end");
	chk_toggle_busy: assert property (
		bus.rd_evt && alg_busy |=> act_tog != $past(act_tog))
		else $error("activity bit did not toggle while busy");
	chk_toggle_stop: assert property (
		bus.rd_evt && !alg_busy |=> act_tog == $past(act_tog))
		else $error("activity bit toggled after completion");
	chk_poll_invert: assert property (
		alg_busy && !burst_on |=> dq_out[fpsi_pkg::POLL_BIT] == $past(poll_bit))
		else $error("polled bit not inverted while busy");
	chk_suspend_sector: assert property (
		bus.rd_evt && !in_susp |=> susp_tog == $past(susp_tog))
		else $error("suspend bit toggled outside suspended sector");
	chk_ready_lead: assert property (
		burst_on && ready_lead_select && bus.clk_rise && emit && bus.ce_low
		&& !bus.burst_start ##1 ready_lead_select |-> rdy)
		else $error("ready not with data");
	chk_ready_early: assert property (
		burst_on && !ready_lead_select && bus.clk_rise && will_emit && bus.ce_low
		&& !bus.burst_start ##1 !ready_lead_select |-> rdy)
		else $error("ready not one clock early");
	chk_no_boundary: assert property (
		burst_on && !freq_above_66 && !boundary_crossing_select
		&& $stable(freq_above_66) && $stable(boundary_crossing_select) |-> !extra)
		else $error("boundary wait inserted at low frequency");
	chk_boundary_stall: assert property (
		burst_on && bus.clk_rise && emit && bnd && bus.ce_low && !bus.burst_start
		|=> extra && valid)
		else $error("boundary delay not inserted");
	chk_stall_gap: assert property (
		burst_on && bus.clk_rise && extra && bus.ce_low && !bus.burst_start
		|=> !valid && !extra)
		else $error("data emitted in boundary delay cycle");
	chk_wait_load: assert property (
		bus.burst_start && bus.ce_low |=> wait_cnt >= fpsi_pkg::WAIT_BASE
		&& wait_cnt == $past(wait_total))
		else $error("initial wait count out of range");

	cov_program: cover property (prog_evt);
	cov_erase: cover property (erase_go);
	cov_sync_write: cover property (bus.wr_evt && bus.wr_sync);
	cov_boundary: cover property (burst_on && extra);
endmodule
`default_nettype wire

// File: src/fpsi_pkg.sv
// Shared constants and types for the flash program and status interface
package fpsi_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int LOW_W = 14;
	localparam int SECT_W = ADDR_W - LOW_W;
	// Unlock addresses and command codes, compared on the low address bits only
	localparam logic [LOW_W-1:0] UNLOCK_ADDR_A = 14'h0555;
	localparam logic [LOW_W-1:0] UNLOCK_ADDR_B = 14'h02AA;
	localparam logic [7:0] CODE_UNLOCK_A = 8'hAA;
	localparam logic [7:0] CODE_UNLOCK_B = 8'h55;
	localparam logic [7:0] CODE_PROGRAM = 8'hA0;
	localparam logic [7:0] CODE_ERASE = 8'h80;
	localparam logic [7:0] CODE_SECTOR = 8'h30;
	localparam logic [7:0] CODE_RESET = 8'hF0;
	// Status bit positions
	localparam int POLL_BIT = 7;
	localparam int ACT_BIT = 6;
	localparam int SUSP_BIT = 2;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int ERASE_ACCEPT_NS = 50000;
	localparam int ERASE_ACCEPT_CYC = ERASE_ACCEPT_NS / CLK_PERIOD_NS;
	localparam int WIN_W = 10;
	localparam logic [2:0] WAIT_BASE = 3'h2;
	localparam logic [2:0] WAIT_MAX_CODE = 3'h5;
	localparam logic [2:0] OFFSET_SAT = 3'h4;
	localparam logic [2:0] OFFSET_RST = 3'h0;
	typedef enum logic [2:0] {
		S_IDLE, S_UNLK2, S_CMD, S_PROG, S_ERS1, S_ERS2, S_ERS3, S_EWIN
	} fpsi_seq_t;
endpackage

// File: verif/fpsi_flash_prog_status_tb.sv
// Self-checking bench for the flash program and status interface
`timescale 1ns/1ps
`default_nettype none
module fpsi_flash_prog_status_tb;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic ce_n, address_valid_n, we_n, oe_n, link_clk, dq_oe, rdy;
	logic prog_evt, erase_sector_evt, erase_go;
	logic [23:0] addr, read_addr, prog_addr;
	logic [15:0] dq_in, dq_out, prog_data;
	logic [15:0] array_data = 16'h0000;
	logic [9:0] erase_sector;
	logic [9:0] suspended_sector = 10'h000;
	logic [2:0] wait_state_field = 3'h0;
	logic sync_read_mode = 1'b0;
	logic ready_lead_select = 1'b1;
	logic boundary_crossing_select = 1'b0;
	logic freq_above_66 = 1'b0;
	logic alg_busy = 1'b0;
	logic erase_suspended = 1'b0;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	int n_prog = 0;
	int n_sect = 0;
	int n_go = 0;
	int t_go = 0;
	int n_oe = 0;
	always #50 clock = ~clock;
	fpsi_host_model u_host (.clock(clock), .dq_out(dq_out), .rdy(rdy), .ce_n(ce_n),
		.address_valid_n(address_valid_n), .we_n(we_n), .oe_n(oe_n),
		.link_clk(link_clk), .addr(addr), .dq_in(dq_in));
	fpsi_flash_prog_status u_dut (.clock(clock), .nrst(nrst), .ce_n(ce_n),
		.address_valid_n(address_valid_n), .we_n(we_n), .oe_n(oe_n), .link_clk(link_clk),
		.addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rdy(rdy),
		.sync_read_mode(sync_read_mode), .ready_lead_select(ready_lead_select),
		.boundary_crossing_select(boundary_crossing_select),
		.wait_state_field(wait_state_field), .freq_above_66(freq_above_66),
		.alg_busy(alg_busy), .erase_suspended(erase_suspended),
		.suspended_sector(suspended_sector), .array_data(array_data),
		.read_addr(read_addr), .prog_evt(prog_evt), .prog_addr(prog_addr),
		.prog_data(prog_data), .erase_sector_evt(erase_sector_evt),
		.erase_sector(erase_sector), .erase_go(erase_go));
	function automatic logic [15:0] word_of(input logic [23:0] a);
		return a[15:0] ^ 16'h5A3C;
	endfunction
	// Event counters and the hang limit
	always @(posedge clock)
	begin
		array_data <= word_of(read_addr);
		cyc <= cyc + 1;
		if (prog_evt === 1'b1) n_prog <= n_prog + 1;
		if (erase_sector_evt === 1'b1) n_sect <= n_sect + 1;
		if (erase_go === 1'b1) n_go <= n_go + 1;
		if (erase_go === 1'b1) t_go <= cyc;
		if (dq_oe === 1'b1) n_oe <= n_oe + 1;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr_low(input logic [13:0] a, input logic [7:0] c);
		u_host.wr({10'($urandom), a}, {8'($urandom), c}, 1'b0, 24'h000000);
	endtask
	task automatic cmd(input logic [7:0] c);
		wr_low(fpsi_pkg::UNLOCK_ADDR_A, fpsi_pkg::CODE_UNLOCK_A);
		wr_low(fpsi_pkg::UNLOCK_ADDR_B, fpsi_pkg::CODE_UNLOCK_B);
		u_host.wr({10'h000, fpsi_pkg::UNLOCK_ADDR_A}, {8'h00, c}, 1'b0, 24'h000000);
	endtask
	task automatic erase_seq(input logic [7:0] c);
		cmd(fpsi_pkg::CODE_ERASE);
		wr_low(fpsi_pkg::UNLOCK_ADDR_A, fpsi_pkg::CODE_UNLOCK_A);
		wr_low(fpsi_pkg::UNLOCK_ADDR_B, fpsi_pkg::CODE_UNLOCK_B);
		u_host.wr({10'($urandom), 14'h0000}, {8'h00, c}, 1'b0, 24'h000000);
	endtask
	initial
	begin
		logic [23:0] pa, pb, qa;
		logic [15:0] pd, w, r1, r2;
		logic [9:0] sb;
		logic [7:0] rv;
		int n, t0;
		void'($urandom(78));
		repeat (12) @(negedge clock);
		nrst = 1'b1;
		repeat (6) @(negedge clock);
		check(rdy, 1'b1);
		check(dq_oe, 1'b0);
		// ------------------------------------------------------------
		// Program: strobe-timed, then clocked in both read modes
		// ------------------------------------------------------------
		for (int m = 0; m < 3; m++)
		begin
			sync_read_mode = (m == 2);
			pa = 24'($urandom);
			pb = 24'($urandom);
			pd = 16'($urandom);
			// A low byte equal to the reset code would abandon the program
			pd[7:0] = (pd[7:0] == fpsi_pkg::CODE_RESET) ? 8'h00 : pd[7:0];
			cmd(fpsi_pkg::CODE_PROGRAM);
			u_host.wr(pa, pd, m > 0, pb);
			check(n_prog, m + 1);
			check(prog_addr, (m == 1) ? pb : pa);
			check(prog_data, pd);
		end
		// ------------------------------------------------------------
		// Status polling, busy then complete, then suspended sector
		// ------------------------------------------------------------
		sync_read_mode = 1'b0;
		w = word_of(pa);
		alg_busy = 1'b1;
		u_host.rd(pa, 1'b0, r1);
		u_host.rd(pa, 1'b1, r2);
		check(r2[6], !r1[6]);
		check(r1[7], !pd[7]);
		check(r2[15:8], w[15:8]);
		alg_busy = 1'b0;
		u_host.rd(pa, 1'b0, r1);
		u_host.rd(pa, 1'b1, r2);
		check(r1, w);
		check(r2, r1);
		erase_suspended = 1'b1;
		suspended_sector = pa[23:14];
		u_host.rd(pa, 1'b0, r1);
		u_host.rd(pa, 1'b1, r2);
		check(r2[2], !r1[2]);
		qa = {~pa[23:14], pa[13:0]};
		u_host.rd(qa, 1'b0, r1);
		u_host.rd(qa, 1'b1, r2);
		check(r1, word_of(qa));
		check(r2, r1);
		erase_suspended = 1'b0;
		// Each status read holds both strobes low for eleven clocks
		check(n_oe, 88);
		// ------------------------------------------------------------
		// Sector erase: window timeout, then early close by another code
		// ------------------------------------------------------------
		n = n_go;
		erase_seq(fpsi_pkg::CODE_SECTOR);
		t0 = cyc;
		sb = 10'($urandom);
		u_host.wr({sb, 14'h0000}, {8'h00, fpsi_pkg::CODE_SECTOR}, 1'b0, 24'h000000);
		check(n_sect, 2);
		check(erase_sector, sb);
		repeat (fpsi_pkg::ERASE_ACCEPT_CYC) @(negedge clock);
		check(n_go, n + 1);
		check(t_go > t0 + fpsi_pkg::ERASE_ACCEPT_CYC - 30, 1'b1);
		erase_seq(fpsi_pkg::CODE_SECTOR);
		u_host.wr(24'($urandom), 16'h0000, 1'b0, 24'h000000);
		check(n_go, n + 2);
		// ------------------------------------------------------------
		// Bursts: every wait code, ready lead alternating with the code, then boundaries
		// ------------------------------------------------------------
		sync_read_mode = 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			wait_state_field = 3'(c);
			ready_lead_select = c[0];
			u_host.burst(24'($urandom) & 24'hFFFFFC, rv);
			n = (c > 5 ? 5 : c) + c[0];
			check(rv, 8'(8'hFF << n));
		end
		wait_state_field = 3'h0;
		ready_lead_select = 1'b1;
		for (int b = 0; b < 3; b++)
		begin
			boundary_crossing_select = (b == 1);
			freq_above_66 = (b == 2);
			u_host.burst((24'($urandom) & 24'hFFFFFC) | 24'h000001, rv);
			check(rv, (b == 0) ? 8'hFE : 8'hEE);
		end
		end_sim();
	end
endmodule
`default_nettype wire

// File: verif/fpsi_host_model.sv
// Host memory controller model driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module fpsi_host_model (
	input wire logic clock,
	input wire logic [15:0] dq_out,
	input wire logic rdy,
	output logic ce_n,
	output logic address_valid_n,
	output logic we_n,
	output logic oe_n,
	output logic link_clk,
	output logic [23:0] addr,
	output logic [15:0] dq_in
);
	// Link clock stands still low outside frames
	initial
	begin
		ce_n = 1'b1;
		address_valid_n = 1'b1;
		we_n = 1'b1;
		oe_n = 1'b1;
		link_clk = 1'b0;
		addr = 24'h000000;
		dq_in = 16'h0000;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic link(input int n);
		repeat (n)
		begin
			link_clk = 1'b1;
			idle(4);
			link_clk = 1'b0;
			idle(4);
		end
	endtask
	// Clocked write latches a_clk at the link rise, then moves the bus to a_we
	task automatic wr(input logic [23:0] a_clk, input logic [15:0] d, input logic clk_w,
		input logic [23:0] a_we);
		@(negedge clock);
		ce_n = 1'b0;
		addr = a_clk;
		dq_in = d;
		address_valid_n = ~clk_w;
		if (clk_w)
		begin
			idle(3);
			link(1);
			addr = a_we;
		end
		idle(1);
		we_n = 1'b0;
		idle(4);
		we_n = 1'b1;
		idle(4);
		ce_n = 1'b1;
		address_valid_n = 1'b1;
		// Released bus shows the inverse, so a stale word cannot pass as held data
		dq_in = ~d;
		idle(2);
	endtask
	// Status reads come in pairs from the caller; by_ce starts the cycle with chip select
	task automatic rd(input logic [23:0] a, input logic by_ce, output logic [15:0] d);
		@(negedge clock);
		addr = a;
		address_valid_n = 1'b0;
		oe_n = ~by_ce;
		ce_n = by_ce;
		idle(3);
		oe_n = 1'b0;
		ce_n = 1'b0;
		idle(3);
		address_valid_n = 1'b1;
		idle(8);
		d = dq_out;
		oe_n = 1'b1;
		ce_n = 1'b1;
		idle(4);
	endtask
	// Samples ready at the end of each of eight link periods after the start rise, four clocks after each link fall
	task automatic burst(input logic [23:0] a, output logic [7:0] r);
		@(negedge clock);
		ce_n = 1'b0;
		oe_n = 1'b0;
		addr = a;
		address_valid_n = 1'b0;
		idle(3);
		link(1);
		address_valid_n = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			link(1);
			r[i] = rdy;
		end
		ce_n = 1'b1;
		oe_n = 1'b1;
		idle(4);
	endtask
endmodule
`default_nettype wire
